// ---- tb_top.sv ----
// Self-checking bench for the capture and reload timer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
	logic [7:0]  address = 8'h00;
	logic [31:0] writedata = 32'h0, readdata;
	logic        waitrequest, countInputPin, captureTriggerPin;
	logic        timer1Overflow, rxBaudTick, txBaudTick, clockOut, timerIrq;
	int          rxCount, txCount, rx0, tx0, nFail = 0, checked = 0;
	int          toggles = 0;
	logic        lastOut;
	always #2 mclk = ~mclk;
	tmr_timer dut_u (.mclk, .nrst, .address, .read, .write,
		.byteenable(4'h1), .writedata, .readdata, .waitrequest,
		.countInputPin, .captureTriggerPin, .timer1Overflow,
		.rxBaudTick, .txBaudTick, .clockOut, .timerIrq);
	tmr_far_side far_u (.mclk, .rxBaudTick, .txBaudTick, .countInputPin,
		.captureTriggerPin, .timer1Overflow, .rxCount, .txCount);
	task automatic close_out;
		if (nFail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic ck(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			nFail++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk);
		address <= a;
		writedata <= {24'h0, d};
		write <= 1'b1;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge mclk);
		address <= a;
		read <= 1'b1;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		ck($sformatf("reg %h", a), {24'h0, e}, readdata);
		read <= 1'b0;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		nFail++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(8'hC8, 8'h00);
		rd(8'h40, 8'h00);
		wr(8'hC9, 8'hFF);
		rd(8'hC9, 8'h0B);
		wr(8'hC9, 8'h00);
		wr(8'hCE, 8'h01);
		wr(8'hCA, 8'hF0);
		wr(8'hCB, 8'h12);
		wr(8'hCC, 8'hF8);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h04);
		repeat (45) @(posedge mclk);
		rd(8'hC8, 8'h84);
		wr(8'hC8, 8'h00);
		rd(8'hCD, 8'h12);
		wr(8'hCC, 8'h55);
		repeat (40) @(posedge mclk);
		rd(8'hCC, 8'h55);
		wr(8'hCC, 8'h00);
		wr(8'hC8, 8'h06);
		repeat (3) far_u.pulse(1'b0);
		wr(8'hC8, 8'h00);
		rd(8'hCC, 8'h03);
		wr(8'hCC, 8'h34);
		wr(8'hCD, 8'h12);
		wr(8'hC9, 8'h08);
		wr(8'hC8, 8'h01);
		far_u.pulse(1'b1);
		rd(8'hC8, 8'h01);
		wr(8'hC8, 8'h09);
		far_u.pulse(1'b1);
		rd(8'hC8, 8'h49);
		rd(8'hCA, 8'h34);
		rd(8'hCB, 8'h12);
		rd(8'hCC, 8'h00);
		wr(8'hCE, 8'h03);
		wr(8'hC8, 8'h00);
		@(negedge mclk);
		ck("timerIrq", 32'h0, {31'h0, timerIrq});
		wr(8'hC8, 8'h40);
		@(negedge mclk);
		ck("timerIrq", 32'h1, {31'h0, timerIrq});
		wr(8'hC8, 8'h00);
		wr(8'hCA, 8'hF0);
		wr(8'hCB, 8'hFF);
		wr(8'hCC, 8'hF0);
		wr(8'hCD, 8'hFF);
		wr(8'hC9, 8'h02);
		wr(8'hC8, 8'h30);
		repeat (8) @(posedge mclk);
		rd(8'hCC, 8'hF0);
		wr(8'hC8, 8'h35);
		@(negedge mclk);
		rx0 = rxCount;
		tx0 = txCount;
		lastOut = clockOut;
		repeat (320) begin
			@(negedge mclk);
			if (clockOut !== lastOut)
				toggles++;
			lastOut = clockOut;
		end
		ck("rxTicks", 32'h1, {31'h0, (rxCount - rx0) inside {[9:11]}});
		ck("txTicks", 32'h1, {31'h0, (txCount - tx0) inside {[9:11]}});
		ck("clockOutToggles", 32'h1, {31'h0, toggles inside {[9:11]}});
		rd(8'hC8, 8'h35);
		wr(8'hC8, 8'h15);
		@(negedge mclk);
		rx0 = rxCount;
		repeat (70) @(negedge mclk);
		ck("rxTicks", 32'd10, rxCount - rx0);
		close_out;
	end
endmodule // tb_top
`default_nettype wire

// ---- tmr_defines.vh ----
// Constants for the capture and auto-reload timer block.
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH
`define TMR_ADDR_W 8
`define TMR_OFS_CTRL 8'hC8
`define TMR_OFS_MODE 8'hC9
`define TMR_OFS_RCAPL 8'hCA
`define TMR_OFS_RCAPH 8'hCB
`define TMR_OFS_CNTL 8'hCC
`define TMR_OFS_CNTH 8'hCD
`define TMR_OFS_AUX 8'hCE
`define TMR_RST_CTRL 8'h00
`define TMR_RST_MODE 8'h00
`define TMR_MODE_MASK 8'h0B
`define TMR_BIT_OVF 7
`define TMR_BIT_EXT 6
`define TMR_BIT_RCLK 5
`define TMR_BIT_TCLK 4
`define TMR_BIT_EXEN 3
`define TMR_BIT_RUN 2
`define TMR_BIT_CT 1
`define TMR_BIT_CPRL 0
`define TMR_BIT_CLR 3
`define TMR_BIT_OE 1
`define TMR_BIT_DOWN_COUNT_ENABLE 0
`define TMR_BIT_SPEED 0
`define TMR_BIT_IEN 1
`define TMR_SLOW_DIV 12
`define TMR_FAST_DIV 4
`define TMR_BAUD_DIV 2
`endif

// ---- tmr_edge_sync.v ----
// Two-flop synchroniser with a one-shot falling-edge detector.
`timescale 1ns/1ps
`default_nettype none
module tmr_edge_sync (
	input  wire mclk,
	input  wire rstN,
	input  wire pinIn,
	output wire level,
	output wire fall
);
	reg meta;
	reg sync;
	reg last;

	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			meta <= 1'b1;
			sync <= 1'b1;
			last <= 1'b1;
		end else begin
			meta <= pinIn;
			sync <= meta;
			last <= sync;
		end
	end

	assign level = sync;
	assign fall = last & ~sync;
endmodule // tmr_edge_sync
`default_nettype wire

// ---- tmr_far_side.sv ----
// Far-side model: timer 1 overflow, input pins and serial tick counters.
`timescale 1ns/1ps
`default_nettype none
module tmr_far_side #(
	parameter int T1_DIV = 7
) (
	input  wire logic mclk,
	input  wire logic rxBaudTick,
	input  wire logic txBaudTick,
	output var logic  countInputPin = 1'b1,
	output var logic  captureTriggerPin = 1'b1,
	output var logic  timer1Overflow = 1'b0,
	output var int    rxCount = 0,
	output var int    txCount = 0
);
	int div = 0;
	// The serial side counts every baud tick it is handed.
	always @(posedge mclk) begin
		div <= (div == T1_DIV - 1) ? 0 : div + 1;
		timer1Overflow <= (div == 0);
		rxCount <= rxCount + int'(rxBaudTick);
		txCount <= txCount + int'(txBaudTick);
	end
	// Pulses are long enough to pass the synchroniser once each.
	task automatic pulse(input bit trig);
		@(posedge mclk);
		if (trig)
			captureTriggerPin <= 1'b0;
		else
			countInputPin <= 1'b0;
		repeat (5) @(posedge mclk);
		captureTriggerPin <= 1'b1;
		countInputPin <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask
endmodule // tmr_far_side
`default_nettype wire

// ---- tmr_timer.v ----
// Capture and auto-reload timer with Avalon-MM register access.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.vh"
module tmr_timer #(
	parameter SLOW_DIV = `TMR_SLOW_DIV,
	parameter FAST_DIV = `TMR_FAST_DIV
) (
	input  wire       mclk,
	input  wire       nrst,
	input  wire [7:0] address,
	input  wire       read,
	input  wire       write,
	input  wire [3:0] byteenable,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output wire       waitrequest,
	input  wire       countInputPin,
	input  wire       captureTriggerPin,
	input  wire       timer1Overflow,
	output wire       rxBaudTick,
	output wire       txBaudTick,
	output reg        clockOut,
	output wire       timerIrq
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	reg rstMeta;
	reg rstN;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	wire trigLevel;
	wire trigFall;
	wire cntFall;
	tmr_edge_sync uTrig (
		.mclk  (mclk),
		.rstN  (rstN),
		.pinIn (captureTriggerPin),
		.level (trigLevel),
		.fall  (trigFall)
	);
	tmr_edge_sync uCnt (
		.mclk  (mclk),
		.rstN  (rstN),
		.pinIn (countInputPin),
		.level (),
		.fall  (cntFall)
	);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [7:0] timerControl;
	reg [7:0] timerModeControl;
	reg [7:0] reloadLow;
	reg [7:0] reloadHigh;
	reg [15:0] count;
	reg [1:0] aux;
	reg [7:0] prescale;
	reg baudPhase;
	reg swExtSet;

	wire overflowFlag = timerControl[`TMR_BIT_OVF];
	wire rxClockSelect = timerControl[`TMR_BIT_RCLK];
	wire txClockSelect = timerControl[`TMR_BIT_TCLK];
	wire externalEnable = timerControl[`TMR_BIT_EXEN];
	wire runControl = timerControl[`TMR_BIT_RUN];
	wire counterTimerSelect = timerControl[`TMR_BIT_CT];
	wire captureReloadSelect = timerControl[`TMR_BIT_CPRL];
	wire captureAutoClear = timerModeControl[`TMR_BIT_CLR];
	wire clockOutEnable = timerModeControl[`TMR_BIT_OE];
	wire downCountEnable = timerModeControl[`TMR_BIT_DOWN_COUNT_ENABLE];
	wire timerSpeedSelect = aux[`TMR_BIT_SPEED];
	wire irqEnable = aux[`TMR_BIT_IEN];

	wire baudMode = rxClockSelect | txClockSelect;
	wire trigAct = trigFall & externalEnable & ~baudMode;
	wire captureMode = captureReloadSelect & ~baudMode;
	wire downMode = ~captureMode & ~baudMode & downCountEnable & ~trigLevel;
	wire [15:0] reloadVal = {reloadHigh, reloadLow};

	// ------------------------------------------------------------
	// Tick generation
	// ------------------------------------------------------------
	wire [7:0] divTop = timerSpeedSelect ? FAST_DIV[7:0] - 8'h01
		: SLOW_DIV[7:0] - 8'h01;
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			prescale <= 8'h00;
			baudPhase <= 1'b0;
		end else begin
			prescale <= (prescale >= divTop) ? 8'h00 : prescale + 8'h01;
			baudPhase <= ~baudPhase;
		end
	end
	// The prescaler runs free, so the first tick after a start may
	// come early by up to one prescale period.
	// Baud every two clocks.
	wire baudTick = baudPhase;
	wire srcTick = counterTimerSelect ? cntFall : (prescale == divTop);
	wire tick = runControl & (baudMode ? baudTick : srcTick);

	wire upOvf = tick & ~downMode & (count == 16'hFFFF);
	wire downOvf = tick & downMode & (count == reloadVal);
	wire ovf = upOvf | downOvf;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	localparam [2:0] IDX_CTRL  = 3'h0;
	localparam [2:0] IDX_MODE  = 3'h1;
	localparam [2:0] IDX_RCAPL = 3'h2;
	localparam [2:0] IDX_RCAPH = 3'h3;
	localparam [2:0] IDX_CNTL  = 3'h4;
	localparam [2:0] IDX_CNTH  = 3'h5;
	localparam [2:0] IDX_AUX   = 3'h6;
	localparam [2:0] IDX_NONE  = 3'h7;

	// Writes and reads share one decode, so a register can never be
	// writable at one offset and readable at another.
	function [2:0] reg_index;
		input [7:0] addr;
		begin
			case (addr)
			`TMR_OFS_CTRL:  reg_index = IDX_CTRL;
			`TMR_OFS_MODE:  reg_index = IDX_MODE;
			`TMR_OFS_RCAPL: reg_index = IDX_RCAPL;
			`TMR_OFS_RCAPH: reg_index = IDX_RCAPH;
			`TMR_OFS_CNTL:  reg_index = IDX_CNTL;
			`TMR_OFS_CNTH:  reg_index = IDX_CNTH;
			`TMR_OFS_AUX:   reg_index = IDX_AUX;
			default:        reg_index = IDX_NONE;
			endcase
		end
	endfunction

	wire [2:0] regIdx = reg_index(address);
	wire wrLane = write & byteenable[0];
	wire wrCtrl = wrLane & (regIdx == IDX_CTRL);
	wire wrMode = wrLane & (regIdx == IDX_MODE);
	wire wrRcl = wrLane & (regIdx == IDX_RCAPL);
	wire wrRch = wrLane & (regIdx == IDX_RCAPH);
	wire wrCl = wrLane & (regIdx == IDX_CNTL);
	wire wrCh = wrLane & (regIdx == IDX_CNTH);
	wire wrAux = wrLane & (regIdx == IDX_AUX);

	// ------------------------------------------------------------
	// Read handshake
	// ------------------------------------------------------------
	// Read data is registered, so every read is held off one cycle
	// and the data already stands when waitrequest drops.
	reg rdDone;
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			rdDone <= 1'b0;
		end else begin
			rdDone <= read & ~rdDone;
		end
	end
	assign waitrequest = read & ~rdDone;
	wire rdLoad = read & ~rdDone;

	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			readdata <= 32'h00000000;
		end else if (rdLoad) begin
			case (regIdx)
			IDX_CTRL: begin
				readdata <= {24'h000000, timerControl};
			end
			IDX_MODE: begin
				readdata <= {24'h000000, timerModeControl};
			end
			IDX_RCAPL: begin
				readdata <= {24'h000000, reloadLow};
			end
			IDX_RCAPH: begin
				readdata <= {24'h000000, reloadHigh};
			end
			IDX_CNTL: begin
				readdata <= {24'h000000, count[7:0]};
			end
			IDX_CNTH: begin
				readdata <= {24'h000000, count[15:8]};
			end
			IDX_AUX: begin
				readdata <= {30'h00000000, aux};
			end
			default: begin
				readdata <= 32'h00000000;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control and flags
	// ------------------------------------------------------------
	reg [7:0] next_ctrl;
	always @* begin
		next_ctrl = wrCtrl ? writedata[7:0] : timerControl;
		if (ovf & ~baudMode)
			next_ctrl[`TMR_BIT_OVF] = 1'b1;
		if (trigAct | (downCountEnable & ovf & ~baudMode & ~captureMode))
			next_ctrl[`TMR_BIT_EXT] = 1'b1;
	end

	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			timerControl <= `TMR_RST_CTRL;
			timerModeControl <= `TMR_RST_MODE;
			aux <= 2'b00;
			swExtSet <= 1'b0;
		end else begin
			timerControl <= next_ctrl;
			if (wrMode)
				timerModeControl <= writedata[7:0] & `TMR_MODE_MASK;
			if (wrAux)
				aux <= writedata[1:0];
			swExtSet <= wrCtrl & writedata[`TMR_BIT_EXT] & ~timerControl[`TMR_BIT_EXT];
		end
	end

	assign timerIrq = irqEnable & (overflowFlag | timerControl[`TMR_BIT_EXT] | swExtSet);

	// ------------------------------------------------------------
	// Counter, capture and reload
	// ------------------------------------------------------------
	localparam [1:0] MODE_RELOAD  = 2'h0;
	localparam [1:0] MODE_CAPTURE = 2'h1;
	localparam [1:0] MODE_DOWN    = 2'h2;
	localparam [1:0] MODE_BAUD    = 2'h3;
	wire [1:0] countMode = baudMode ? MODE_BAUD
		: captureMode ? MODE_CAPTURE
		: downMode ? MODE_DOWN : MODE_RELOAD;

	reg [15:0] next_count;
	reg [7:0]  next_reloadLow;
	reg [7:0]  next_reloadHigh;
	always @* begin
		next_count = count;
		next_reloadLow = wrRcl ? writedata[7:0] : reloadLow;
		next_reloadHigh = wrRch ? writedata[7:0] : reloadHigh;
		case (countMode)
		MODE_CAPTURE: begin
			if (trigAct) begin
				next_reloadLow = count[7:0];
				next_reloadHigh = count[15:8];
			end
			if (trigAct & captureAutoClear)
				next_count = 16'h0000;
			else if (tick)
				next_count = count + 16'h0001;
		end
		MODE_DOWN: begin
			if (trigAct)
				next_count = reloadVal;
			else if (downOvf)
				next_count = 16'hFFFF;
			else if (tick)
				next_count = count - 16'h0001;
		end
		MODE_BAUD: begin
			if (upOvf)
				next_count = reloadVal;
			else if (tick)
				next_count = count + 16'h0001;
		end
		default: begin
			if (trigAct | upOvf)
				next_count = reloadVal;
			else if (tick)
				next_count = count + 16'h0001;
		end
		endcase
		// A count byte written by software wins over a tick of the
		// same cycle, so a preset value is never lost.
		if (wrCl)
			next_count[7:0] = writedata[7:0];
		if (wrCh)
			next_count[15:8] = writedata[7:0];
	end

	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			count <= 16'h0000;
			reloadLow <= 8'h00;
			reloadHigh <= 8'h00;
		end else begin
			count <= next_count;
			reloadLow <= next_reloadLow;
			reloadHigh <= next_reloadHigh;
		end
	end

	// ------------------------------------------------------------
	// Baud and clock output
	// ------------------------------------------------------------
	// Receive and transmit time bases.
	assign rxBaudTick = rxClockSelect ? (ovf & baudMode) : timer1Overflow;
	assign txBaudTick = txClockSelect ? (ovf & baudMode) : timer1Overflow;

	// Clock out follows up overflows only; a down count never
	// toggles it, so software must not rely on it in that mode.
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			clockOut <= 1'b0;
		end else if (!clockOutEnable) begin
			clockOut <= 1'b0;
		end else if (upOvf) begin
			clockOut <= ~clockOut;
		end
	end
endmodule // tmr_timer
`default_nettype wire

// ---- tmr_timer_checker.sv ----
// Port-level assertions for the capture and reload timer.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer_checker (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic [7:0]  address,
	input wire logic        write,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] writedata,
	input wire logic        timer1Overflow,
	input wire logic        rxBaudTick,
	input wire logic        txBaudTick,
	input wire logic        clockOut,
	input wire logic        timerIrq
);
	// Software alone writes these bits, so a shadow of the writes is exact.
	logic [5:0] ctrl;
	logic       outEn;
	logic       irqEn;
	wire        wrEn = write && byteenable[0];
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= 6'h00;
			outEn <= 1'b0;
			irqEn <= 1'b0;
		end else if (wrEn && address == 8'hC8) begin
			ctrl <= writedata[5:0];
		end else if (wrEn && address == 8'hC9) begin
			outEn <= writedata[1];
		end else if (wrEn && address == 8'hCE) begin
			irqEn <= writedata[1];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_swSetExt;
		wrEn && address == 8'hC8 && writedata[6] && irqEn;
	endsequence
	chk_rx_timer1: assert property (!ctrl[5] |-> rxBaudTick == timer1Overflow)
		else $error("rx tick not from timer 1");
	chk_tx_timer1: assert property (!ctrl[4] |-> txBaudTick == timer1Overflow)
		else $error("tx tick not from timer 1");
	chk_rx_spacing: assert property (ctrl[5] && rxBaudTick |=> !rxBaudTick)
		else $error("rx ticks closer than two clocks");
	chk_tx_spacing: assert property (ctrl[4] && txBaudTick |=> !txBaudTick)
		else $error("tx ticks closer than two clocks");
	chk_baud_halted: assert property (ctrl[5] && !ctrl[2] && !$past(ctrl[2])
		|-> !rxBaudTick) else $error("tick while stopped");
	chk_irq_masked: assert property (!irqEn |-> !timerIrq)
		else $error("interrupt while disabled");
	chk_irq_swset: assert property (s_swSetExt |=> timerIrq)
		else $error("no interrupt on software flag set");
	chk_clkout_hold: assert property (!outEn && !$past(outEn) |=> $stable(clockOut))
		else $error("clock out moved while disabled");
endmodule // tmr_timer_checker
bind tmr_timer tmr_timer_checker chk_u (.mclk, .nrst, .address, .write,
	.byteenable, .writedata, .timer1Overflow, .rxBaudTick, .txBaudTick,
	.clockOut, .timerIrq);
`default_nettype wire
